// ==== dpc_pkg.sv ====
// Package of addresses, command and result codes, reset values and timing counts for the power-control register set.
`default_nettype none
package dpc_pkg;
	localparam logic [15:0] DPC_ADDR_RIPPLE = 16'hf000;
	localparam logic [15:0] DPC_ADDR_LIMIT = 16'hf001;
	localparam logic [15:0] DPC_ADDR_PF_HI = 16'hf002;
	localparam logic [15:0] DPC_ADDR_PF_LO = 16'hf003;
	localparam logic [15:0] DPC_ADDR_COMMIT = 16'hf100;
	localparam logic [15:0] DPC_ADDR_RESTORE = 16'hf101;
	localparam logic [15:0] DPC_ADDR_STAGED_BASE = 16'hf102;
	localparam logic [15:0] DPC_ADDR_MODE = 16'hf104;
	localparam logic [15:0] DPC_ADDR_ENABLE = 16'hf142;
	localparam logic [15:0] DPC_CMD_EXECUTE = 16'h0001;
	localparam logic [15:0] DPC_RES_OK = 16'h0000;
	localparam logic [15:0] DPC_RES_UNKNOWN = 16'hffff;
	localparam logic [15:0] DPC_LIMIT_MAX = 16'h0064;
	localparam logic [15:0] DPC_LIMIT_RESET = 16'h0064;
	localparam logic [31:0] DPC_PF_RESET = 32'h3f800000;
	localparam logic [31:0] DPC_PF_ONE_MAG = 32'h3f800000;
	localparam logic [15:0] DPC_MODE_FIXED_PF = 16'h0000;
	localparam logic [15:0] DPC_MODE_RIPPLE = 16'h0004;
	localparam logic [15:0] DPC_MODE_MAX = 16'h0004;
	localparam logic [15:0] DPC_ENABLE_RESET = 16'h0000;
	localparam int DPC_CLK_HZ = 20000000;
	localparam int DPC_COMMIT_MIN_S = 5;
	localparam int DPC_COMMIT_MAX_S = 10;
	localparam int DPC_RESTORE_MIN_S = 3;
	localparam int DPC_RESTORE_MAX_S = 6;
	localparam int DPC_COMMIT_CYC = DPC_COMMIT_MIN_S * DPC_CLK_HZ;
	localparam int DPC_RESTORE_CYC = DPC_RESTORE_MIN_S * DPC_CLK_HZ;
	localparam int DPC_TIMER_W = 32;
	typedef enum logic [2:0] {
		DPC_IDLE = 3'b001,
		DPC_COMMIT = 3'b010,
		DPC_RESTORE = 3'b100
	} dpc_op_type;
endpackage : dpc_pkg
`default_nettype wire

// ==== dpc_regs.sv ====
// Dynamic power-control, commit and restore register set of the inverter.
`timescale 1ns/1ns
`default_nettype none
// Function
// (R1) Dynamic command group sits at word address 0xF000.
// (R2) F000 reads the four ripple-receiver input levels, 0 to 15, read-only.
// (R3) F001 holds the 0..100 percent active power limit, applied as output ceiling.
// (R4) Dynamic values apply immediately and are lost on restart.
// (R5) F002/F003 hold a 32-bit float power-factor setpoint, -1.0..1.0, applied immediately; values outside the range are stored and only clear controls_operative.
// (R6) Grid-control enable at 0xF142 resets to 0; controller writes 1.
// (R7) Reactive mode selector at 0xF104 resets to 0; controller writes 4.
// (R8) Enable and mode changes take effect only after a commit.
// (R9) Commit copies all staged settings from 0xF102 upward into effect.
// (R10) Writing 1 to commit starts it; it runs five to ten seconds.
// (R11) Commit reads 0 ok, 1-4 internal, failing address, or all-ones unknown.
// (R12) Restore returns settings to country defaults, leaving the country unchanged.
// (R13) Writing 1 to F101 starts restore; it runs three to six seconds.
// (R14) Restore reads 0 after success and all-ones after failure.
// (R15) Command group at 0xF100: commit F100, restore F101, signed 16-bit.
// (R16) Staged settings are operative only while the enable is 1.
// (R17) Result codes keep their old value until the operation finishes.
module dpc_regs #(
	parameter int COMMIT_CYC = dpc_pkg::DPC_COMMIT_CYC,
	parameter int RESTORE_CYC = dpc_pkg::DPC_RESTORE_CYC,
	parameter logic [15:0] COUNTRY_MODE_DEFAULT = dpc_pkg::DPC_MODE_FIXED_PF
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [3:0] ripple_receiver_inputs,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_err,
	output logic [15:0] power_limit_pct,
	output logic [31:0] power_factor_setpoint,
	output logic grid_control_enable,
	output logic [15:0] reactive_mode_select,
	output logic controls_operative,
	output logic busy
);
	typedef struct packed {
		logic [3:0] ripple;
		logic [15:0] limit;
		logic [31:0] pf;
		logic [15:0] en_stage;
		logic [15:0] mode_stage;
		logic en_eff;
		logic [15:0] mode_eff;
		logic [15:0] commit_res;
		logic [15:0] restore_res;
		logic [15:0] pend_res;
		dpc_pkg::dpc_op_type op;
		logic [dpc_pkg::DPC_TIMER_W-1:0] timer;
		logic [15:0] rdata;
		logic err;
	} dpc_state_type;

	dpc_state_type s_q;
	dpc_state_type s_d;

	// Float magnitude check: sign ignored, value must not exceed 1.0.
	function automatic logic pf_ok(input logic [31:0] v);
		pf_ok = (v[30:0] <= dpc_pkg::DPC_PF_ONE_MAG[30:0]);
	endfunction : pf_ok

	function automatic logic known_addr(input logic [15:0] a);
		known_addr = (a == dpc_pkg::DPC_ADDR_RIPPLE) || (a == dpc_pkg::DPC_ADDR_LIMIT) ||
			(a == dpc_pkg::DPC_ADDR_PF_HI) || (a == dpc_pkg::DPC_ADDR_PF_LO) ||
			(a == dpc_pkg::DPC_ADDR_COMMIT) || (a == dpc_pkg::DPC_ADDR_RESTORE) ||
			(a == dpc_pkg::DPC_ADDR_MODE) || (a == dpc_pkg::DPC_ADDR_ENABLE);
	endfunction : known_addr

	always_comb begin
		s_d = s_q;
		s_d.ripple = ripple_receiver_inputs; // see (R2)
		s_d.err = 1'b0;
		if (reg_wr) begin
			s_d.err = !known_addr(reg_addr) || (reg_addr == dpc_pkg::DPC_ADDR_RIPPLE);
			case (reg_addr)
				dpc_pkg::DPC_ADDR_LIMIT: begin
					// Out-of-range limits are refused rather than clipped, so the ceiling stays sane.
					if (reg_wdata <= dpc_pkg::DPC_LIMIT_MAX) begin
						s_d.limit = reg_wdata; // see (R3) (R4)
					end else begin
						s_d.err = 1'b1;
					end
				end
				dpc_pkg::DPC_ADDR_PF_HI: begin
					s_d.pf[31:16] = reg_wdata; // see (R5)
				end
				dpc_pkg::DPC_ADDR_PF_LO: begin
					s_d.pf[15:0] = reg_wdata; // see (R5)
				end
				dpc_pkg::DPC_ADDR_ENABLE: begin
					s_d.en_stage = reg_wdata; // see (R6) (R8)
				end
				dpc_pkg::DPC_ADDR_MODE: begin
					s_d.mode_stage = reg_wdata; // see (R7) (R8)
				end
				dpc_pkg::DPC_ADDR_COMMIT: begin
					// A command arriving while another runs is refused; the first one finishes.
					if (reg_wdata == dpc_pkg::DPC_CMD_EXECUTE && s_q.op == dpc_pkg::DPC_IDLE) begin
						s_d.op = dpc_pkg::DPC_COMMIT; // see (R10)
						s_d.timer = dpc_pkg::DPC_TIMER_W'(COMMIT_CYC - 1);
						if (s_q.en_stage > 16'h0001) begin
							s_d.pend_res = dpc_pkg::DPC_ADDR_ENABLE; // see (R11)
						end else if (s_q.mode_stage > dpc_pkg::DPC_MODE_MAX) begin
							s_d.pend_res = dpc_pkg::DPC_ADDR_MODE; // see (R11)
						end else begin
							s_d.pend_res = dpc_pkg::DPC_RES_OK;
						end
					end else begin
						s_d.err = 1'b1;
					end
				end
				dpc_pkg::DPC_ADDR_RESTORE: begin
					if (reg_wdata == dpc_pkg::DPC_CMD_EXECUTE && s_q.op == dpc_pkg::DPC_IDLE) begin
						s_d.op = dpc_pkg::DPC_RESTORE; // see (R13)
						s_d.timer = dpc_pkg::DPC_TIMER_W'(RESTORE_CYC - 1);
					end else begin
						s_d.err = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (s_q.op != dpc_pkg::DPC_IDLE) begin
			if (s_q.timer != '0) begin
				s_d.timer = s_q.timer - 1'b1; // see (R17)
			end else begin
				s_d.op = dpc_pkg::DPC_IDLE;
				if (s_q.op == dpc_pkg::DPC_COMMIT) begin
					s_d.commit_res = s_q.pend_res; // see (R11) (R17)
					if (s_q.pend_res == dpc_pkg::DPC_RES_OK) begin
						s_d.en_eff = s_q.en_stage[0]; // see (R9)
						s_d.mode_eff = s_q.mode_stage; // see (R9)
					end
				end else begin
					// Country defaults are restored into both staged and live copies.
					s_d.en_stage = dpc_pkg::DPC_ENABLE_RESET; // see (R12)
					s_d.mode_stage = COUNTRY_MODE_DEFAULT; // see (R12)
					s_d.en_eff = 1'b0;
					s_d.mode_eff = COUNTRY_MODE_DEFAULT;
					s_d.restore_res = dpc_pkg::DPC_RES_OK; // see (R14)
				end
			end
		end
		s_d.rdata = s_q.rdata;
		if (reg_rd) begin
			s_d.err = !known_addr(reg_addr);
			case (reg_addr)
				dpc_pkg::DPC_ADDR_RIPPLE: s_d.rdata = {12'h000, s_q.ripple}; // see (R1) (R2)
				dpc_pkg::DPC_ADDR_LIMIT: s_d.rdata = s_q.limit;
				dpc_pkg::DPC_ADDR_PF_HI: s_d.rdata = s_q.pf[31:16];
				dpc_pkg::DPC_ADDR_PF_LO: s_d.rdata = s_q.pf[15:0];
				dpc_pkg::DPC_ADDR_COMMIT: s_d.rdata = s_q.commit_res; // see (R15)
				dpc_pkg::DPC_ADDR_RESTORE: s_d.rdata = s_q.restore_res; // see (R15)
				dpc_pkg::DPC_ADDR_ENABLE: s_d.rdata = s_q.en_stage;
				dpc_pkg::DPC_ADDR_MODE: s_d.rdata = s_q.mode_stage;
				default: s_d.rdata = dpc_pkg::DPC_RES_UNKNOWN;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.limit <= dpc_pkg::DPC_LIMIT_RESET; // see (R4)
			s_q.pf <= dpc_pkg::DPC_PF_RESET;
			s_q.en_stage <= dpc_pkg::DPC_ENABLE_RESET; // see (R6)
			s_q.mode_stage <= dpc_pkg::DPC_MODE_FIXED_PF; // see (R7)
			s_q.mode_eff <= dpc_pkg::DPC_MODE_FIXED_PF;
			s_q.op <= dpc_pkg::DPC_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// Both flags are registered from the next state, so they stand in the same cycle as the values they describe.
	logic operative_q;
	logic busy_q;
	always_ff @(posedge clk) begin
		if (srst) begin
			operative_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			operative_q <= s_d.en_eff && pf_ok(s_d.pf); // see (R16)
			busy_q <= (s_d.op != dpc_pkg::DPC_IDLE); // see (R10) (R13)
		end
	end

	assign reg_rdata = s_q.rdata;
	assign reg_err = s_q.err;
	assign power_limit_pct = s_q.limit;
	assign power_factor_setpoint = s_q.pf;
	assign grid_control_enable = s_q.en_eff;
	assign reactive_mode_select = s_q.mode_eff;
	assign controls_operative = operative_q; // see (R16)
	assign busy = busy_q;

	a_limit_range: assert property (@(posedge clk) disable iff (srst) power_limit_pct <= dpc_pkg::DPC_LIMIT_MAX) // see (R3)
		else $error("limit out of range");
	a_limit_write: assert property (@(posedge clk) disable iff (srst)
		reg_wr && reg_addr == dpc_pkg::DPC_ADDR_LIMIT && reg_wdata <= dpc_pkg::DPC_LIMIT_MAX |=> power_limit_pct == $past(reg_wdata)) // see (R3)
		else $error("limit not applied");
	a_ripple_read: assert property (@(posedge clk) disable iff (srst)
		reg_rd && reg_addr == dpc_pkg::DPC_ADDR_RIPPLE |=> reg_rdata[15:4] == 12'h000) // see (R2)
		else $error("ripple read high bits");
	a_enable_commit: assert property (@(posedge clk) disable iff (srst)
		!busy ##1 !busy |-> $stable(grid_control_enable) && $stable(reactive_mode_select)) // see (R8)
		else $error("setting changed without commit");
	a_commit_start: assert property (@(posedge clk) disable iff (srst)
		!busy && reg_wr && reg_addr == dpc_pkg::DPC_ADDR_COMMIT && reg_wdata == dpc_pkg::DPC_CMD_EXECUTE |=> busy) // see (R10)
		else $error("commit did not start");
	a_result_hold: assert property (@(posedge clk) disable iff (srst)
		busy ##1 busy |-> $stable(s_q.commit_res) && $stable(s_q.restore_res)) // see (R17)
		else $error("result changed while busy");
	a_restore_start: assert property (@(posedge clk) disable iff (srst)
		!busy && reg_wr && reg_addr == dpc_pkg::DPC_ADDR_RESTORE && reg_wdata == dpc_pkg::DPC_CMD_EXECUTE |=> busy) // see (R13)
		else $error("restore did not start");
	a_operative_gate: assert property (@(posedge clk) disable iff (srst) controls_operative |-> grid_control_enable) // see (R16)
		else $error("operative without enable");
	a_enable_reset: assert property (@(posedge clk) $fell(srst) |-> !grid_control_enable && reactive_mode_select == 16'h0000) // see (R6)
		else $error("enable or mode not reset");

	c_commit_done: cover property (@(posedge clk) disable iff (srst) $fell(busy) && s_q.commit_res == 16'h0000);
	c_restore_run: cover property (@(posedge clk) disable iff (srst) s_q.op == dpc_pkg::DPC_RESTORE);
	c_enabled: cover property (@(posedge clk) disable iff (srst) controls_operative && reactive_mode_select == 16'h0004);
endmodule : dpc_regs
`default_nettype wire

// ==== dpc_master_model.sv ====
// Register-bus master model of the local monitoring and control system.
`timescale 1ns/1ns
`default_nettype none
module dpc_master_model (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end
	// One word per strobe, held until the taking edge.
	// Idle address and data are inverted, so a design that samples them late sees garbage.
	task automatic xfer(input logic rd, input logic [15:0] addr, input logic [15:0] data);
		@(posedge clk);
		reg_rd <= rd;
		reg_wr <= ~rd;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		reg_addr <= ~addr;
		reg_wdata <= ~data;
	endtask : xfer
endmodule : dpc_master_model
`default_nettype wire

// ==== dynamic_power_ctrl_regs_tb.sv ====
// Self-checking bench for the power-control register set.
`timescale 1ns/1ns
`default_nettype none
module dynamic_power_ctrl_regs_tb;
	typedef struct packed {logic rd; logic [15:0] data; logic err;} dpc_note_type;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] ripple_receiver_inputs = 4'h0;
	logic acc_d = 1'b0;
	logic reg_wr, reg_rd, reg_err, grid_control_enable, controls_operative, busy;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, power_limit_pct, reactive_mode_select, lim;
	logic [31:0] power_factor_setpoint;
	logic [3:0] rip;
	dpc_note_type notes[$];
	dpc_note_type note;
	int failures = 0;
	int tests_run = 0;
	int seed = 26;
	int n;
	always #25 clk = ~clk;
	dpc_master_model dpc_master_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata));
	// Short command times keep the run small; the checks below use the same figures.
	dpc_regs #(.COMMIT_CYC(20), .RESTORE_CYC(12)) dpc_regs_i (.clk(clk), .srst(srst),
		.ripple_receiver_inputs(ripple_receiver_inputs), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_err(reg_err), .power_limit_pct(power_limit_pct),
		.power_factor_setpoint(power_factor_setpoint), .grid_control_enable(grid_control_enable),
		.reactive_mode_select(reactive_mode_select), .controls_operative(controls_operative), .busy(busy));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	task automatic acc(input logic rd, input logic [15:0] addr, input logic [15:0] data, input logic [15:0] exp,
		input logic err);
		notes.push_back('{rd, exp, err});
		dpc_master_model_i.xfer(rd, addr, data);
	endtask : acc
	// Counts the cycles that busy stands; a stuck busy ends the run.
	task automatic wait_idle(input int exp_cyc);
		int k;
		n = 0;
		for (k = 0; k < 300; k++) begin
			@(posedge clk);
			if (busy !== 1'b1)
				break;
			n++;
		end
		if (k == 300) begin
			failures++;
			wrap_up();
		end
		if (exp_cyc > 0)
			check("busy cycles", n, exp_cyc);
	endtask : wait_idle
	// Every access answers one cycle after its taking edge.
	always @(posedge clk) begin
		if (acc_d) begin
			note = notes.pop_front();
			if (note.rd)
				check("read data", 32'(reg_rdata), 32'(note.data));
			check("access error", 32'(reg_err), 32'(note.err));
		end
		acc_d <= reg_wr | reg_rd;
	end
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		acc(1, 16'hf001, 0, 16'h0064, 0);
		acc(1, 16'hf002, 0, 16'h3f80, 0);
		acc(1, 16'hf142, 0, 16'h0000, 0);
		acc(1, 16'hf104, 0, 16'h0000, 0);
		acc(1, 16'hf100, 0, 16'h0000, 0);
		acc(1, 16'hf101, 0, 16'h0000, 0);
		rip = 4'($random(seed));
		ripple_receiver_inputs <= rip;
		acc(1, 16'hf000, 0, 16'(rip), 0);
		acc(0, 16'hf000, 16'h0003, 0, 1);
		lim = 16'(($random(seed) & 32'h7fffffff) % 101);
		acc(0, 16'hf001, 16'h0064, 0, 0);
		acc(0, 16'hf001, 16'h0065, 0, 1);
		acc(0, 16'hf001, lim, 0, 0);
		acc(1, 16'hf001, 0, lim, 0);
		check("limit output", 32'(power_limit_pct), 32'(lim));
		acc(0, 16'hf002, 16'hbf80, 0, 0);
		acc(0, 16'hf003, 16'h0000, 0, 0);
		acc(1, 16'hf002, 0, 16'hbf80, 0);
		check("setpoint output", power_factor_setpoint, 32'hbf800000);
		acc(0, 16'hf142, 16'h0001, 0, 0);
		acc(0, 16'hf104, 16'h0004, 0, 0);
		check("enable before commit", 32'(grid_control_enable), 32'h0);
		acc(0, 16'hf100, 16'h0001, 0, 0);
		wait_idle(20);
		check("enable after commit", 32'(grid_control_enable), 32'h1);
		check("mode after commit", 32'(reactive_mode_select), 32'h4);
		check("operative", 32'(controls_operative), 32'h1);
		acc(0, 16'hf002, 16'h4000, 0, 0);
		@(posedge clk);
		check("operative bad setpoint", 32'(controls_operative), 32'h0);
		acc(0, 16'hf002, 16'hbf80, 0, 0);
		@(posedge clk);
		check("operative again", 32'(controls_operative), 32'h1);
		acc(1, 16'hf100, 0, 16'h0000, 0);
		acc(0, 16'hf100, 16'h0002, 0, 1);
		acc(0, 16'hf104, 16'h0005, 0, 0);
		acc(0, 16'hf100, 16'h0001, 0, 0);
		acc(0, 16'hf101, 16'h0001, 0, 1);
		acc(1, 16'hf100, 0, 16'h0000, 0);
		wait_idle(0);
		acc(1, 16'hf100, 0, 16'hf104, 0);
		check("mode kept", 32'(reactive_mode_select), 32'h4);
		acc(0, 16'hf101, 16'h0001, 0, 0);
		wait_idle(12);
		check("enable restored", 32'(grid_control_enable), 32'h0);
		check("mode restored", 32'(reactive_mode_select), 32'h0);
		check("not operative", 32'(controls_operative), 32'h0);
		acc(1, 16'hf101, 0, 16'h0000, 0);
		acc(1, 16'hf0ff, 0, 16'hffff, 1);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		acc(1, 16'hf001, 0, 16'h0064, 0);
		acc(1, 16'hf002, 0, 16'h3f80, 0);
		repeat (2) @(posedge clk);
		wrap_up();
	end
endmodule : dynamic_power_ctrl_regs_tb
`default_nettype wire
